/* File: fpdi_cmd.sv */
/*
 * Command interpreter for sleep entry, wake with device code, maker/device
 * code, identification read and OTP-sector program.
 * Assumes the host drives chip select, serial clock and serial input from
 * outside this clock domain; the serial clock is slow against clk_i.
 * OTP storage and all self-timed array cycles but the OTP program cycle, which is timed here, sit outside this block.
 */
`timescale 1ns/100ps
// Function
// R1: Only the sleep entry command ever puts the device to sleep.
// R2: Asleep, ignore all but wake and soft reset; both wake it.
// R3: Chip select high with no busy cycle means standby, distinct from sleep.
// R4: Sleep entry runs only if chip select rises right after bit eight.
// R5: After valid sleep entry, wait the entry delay, then sleep.
// R6: Sleep entry during a busy cycle is rejected; cycle continues.
// R7: Reset leaves sleep and always starts in standby.
// R8: Wake-only: opcode, chip select high for short wake delay, then accept.
// R9: Wake with three dummy bytes returns device code repeatedly, MSB first.
// R10: Wake ends: standby at once if awake, after read wake delay if asleep.
// R11: Wake returns code when awake; ignored during busy cycles.
// R12: Maker/device read: address zero maker first, address one device first.
// R13: Identification shifts maker, type, capacity; ends when chip select rises.
// R14: Identification during a busy cycle is not decoded.
// R15: Host should not send identification while device sleeps.
// R16: OTP program needs prior write enable; opcode, address, data bytes.
// R17: One OTP program writes one to 256 bytes into erased locations.
// R18: Host keeps chip select low through the whole OTP program.
// R19: Per-sector lock bits; locked sectors ignore OTP program.
// R20: OTP sectors at FFF000h, FFE000h, FFD000h, 512 bytes each.
// R21: OTP program also accepted in quad command mode.
// R22: Capture on rising serial clock, drive output on falling edges.
// R23: Busy flag is one during any self-timed cycle.
// R24: Write enable command sets the write enable latch.
// R25: OTP program starts at chip select rise; latch cleared when done.
module fpdi_cmd (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire fpdi_pkg::fpdi_link_t link_i,
    input wire logic [2:0] otp_lock_bits_i,
    input wire logic quad_command_mode_i,
    input wire logic ext_busy_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic busy_flag_o,
    output logic write_enable_latch_o,
    output logic asleep_o,
    output logic standby_o,
    output fpdi_pkg::fpdi_otp_wr_t otp_wr_o
);

    fpdi_pkg::fpdi_state_t s_q;
    fpdi_pkg::fpdi_state_t s_d;

    logic csn;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic busy;
    logic [7:0] byte_in;
    logic byte_done;
    logic [1:0] otp_sector;
    logic otp_hit;

    // ------------------------------------------------------------------
    // Sampled link
    // ------------------------------------------------------------------
    assign csn = s_q.csn_s[1];
    // R22: rising capture, falling drive
    assign sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_prev;
    assign sclk_fall = ~s_q.sclk_s[1] & s_q.sclk_prev;
    assign cs_rise = csn & ~s_q.csn_prev;
    assign cs_fall = ~csn & s_q.csn_prev;
    // R23: busy during own or external cycle
    assign busy = ext_busy_i | (s_q.power == fpdi_pkg::PW_BUSY);
    assign byte_in = {s_q.shift[6:0], s_q.sin_s[1]};
    assign byte_done = sclk_rise & (s_q.bitcnt == 3'h7);

    // R20: OTP sector decode
    always_comb begin
        otp_hit = 1'b1;
        otp_sector = 2'h0;
        case (s_q.addr & ~fpdi_pkg::OTP_SPAN_MASK)
            fpdi_pkg::OTP_BASE_0: otp_sector = 2'h0;
            fpdi_pkg::OTP_BASE_1: otp_sector = 2'h1;
            fpdi_pkg::OTP_BASE_2: otp_sector = 2'h2;
            default: otp_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.csn_s = {s_q.csn_s[0], link_i.csn};
        s_d.sclk_s = {s_q.sclk_s[0], link_i.sclk};
        s_d.sin_s = {s_q.sin_s[0], link_i.sin};
        s_d.sclk_prev = s_q.sclk_s[1];
        s_d.csn_prev = csn;
        s_d.otp_wr = 1'b0;

        // Power timer
        if (s_q.tmr != '0) begin
            s_d.tmr = s_q.tmr - 1'b1;
        end
        case (s_q.power)
            fpdi_pkg::PW_ENTERING: begin
                // R5: entry delay then sleep
                if (s_q.tmr == '0) begin
                    s_d.power = fpdi_pkg::PW_SLEEP;
                end
            end
            fpdi_pkg::PW_WAKING: begin
                if (s_q.tmr == '0) begin
                    s_d.power = fpdi_pkg::PW_STANDBY;
                end
            end
            fpdi_pkg::PW_BUSY: begin
                // R25: cycle end clears latch
                if (s_q.tmr == '0) begin
                    s_d.power = fpdi_pkg::PW_STANDBY;
                    s_d.write_enable_latch = 1'b0;
                end
            end
            default: begin
            end
        endcase

        // R4: any later bit cancels entry
        if (!csn && sclk_rise) begin
            s_d.sleep_ok = 1'b0;
        end
        if (cs_fall) begin
            s_d.phase = fpdi_pkg::PH_OPCODE;
            s_d.bitcnt = 3'h0;
            s_d.bytecnt = 2'h0;
            s_d.sleep_ok = 1'b0;
            s_d.otp_armed = 1'b0;
            s_d.otp_count = 9'h000;
            // R8: ignore selects during wake and entry delays
            if (s_q.power == fpdi_pkg::PW_WAKING || s_q.power == fpdi_pkg::PW_ENTERING) begin
                s_d.phase = fpdi_pkg::PH_IGNORE;
            end
        end else if (!csn && sclk_rise && s_q.phase != fpdi_pkg::PH_IGNORE) begin
            s_d.shift = byte_in;
            s_d.bitcnt = s_q.bitcnt + 3'h1;
            if (byte_done) begin
                case (s_q.phase)
                    fpdi_pkg::PH_OPCODE: begin
                        s_d.op = byte_in;
                        s_d.phase = fpdi_pkg::PH_IGNORE;
                        // R2: asleep, only wake and soft reset
                        if (s_q.power == fpdi_pkg::PW_SLEEP) begin
                            if (byte_in == fpdi_pkg::OP_WAKE_AND_CODE) begin
                                s_d.phase = fpdi_pkg::PH_DUMMY;
                            end else if (byte_in == fpdi_pkg::OP_SOFT_RESET) begin
                                s_d.power = fpdi_pkg::PW_STANDBY;
                            end
                        // R6: R11: R14: rejected while busy
                        end else if (!busy) begin
                            case (byte_in)
                                // R4: valid only if cs rises next
                                fpdi_pkg::OP_SLEEP_ENTRY: s_d.sleep_ok = 1'b1;
                                fpdi_pkg::OP_WAKE_AND_CODE: s_d.phase = fpdi_pkg::PH_DUMMY;
                                fpdi_pkg::OP_MAKER_DEV: s_d.phase = fpdi_pkg::PH_ADDR;
                                // R13: identification, 24 bits
                                fpdi_pkg::OP_IDENT_READ: begin
                                    s_d.phase = fpdi_pkg::PH_OUT;
                                    s_d.out_word = {fpdi_pkg::MAKER_CODE,
                                                    fpdi_pkg::MEM_TYPE,
                                                    fpdi_pkg::CAPACITY};
                                    s_d.out_len = 5'h17;
                                    s_d.out_idx = 5'h17;
                                end
                                // R24: write enable sets latch
                                fpdi_pkg::OP_WRITE_ENABLE: s_d.write_enable_latch = 1'b1;
                                // R16: R21: needs latch, any mode
                                fpdi_pkg::OP_OTP_PROGRAM: begin
                                    if (s_q.write_enable_latch) begin
                                        s_d.phase = fpdi_pkg::PH_ADDR;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                    fpdi_pkg::PH_ADDR: begin
                        s_d.addr = {s_q.addr[15:0], byte_in};
                        s_d.bytecnt = s_q.bytecnt + 2'h1;
                        if (s_q.bytecnt == 2'h2) begin
                            if (s_q.op == fpdi_pkg::OP_OTP_PROGRAM) begin
                                s_d.phase = fpdi_pkg::PH_DATA;
                            end else begin
                                // R12: order by whole low address byte equal to one
                                s_d.phase = fpdi_pkg::PH_OUT;
                                s_d.out_len = 5'h0F;
                                s_d.out_idx = 5'h0F;
                                s_d.out_word = (byte_in == fpdi_pkg::ADDR_DEV_FIRST[7:0])
                                    ? {8'h00, fpdi_pkg::DEVICE_CODE, fpdi_pkg::MAKER_CODE}
                                    : {8'h00, fpdi_pkg::MAKER_CODE, fpdi_pkg::DEVICE_CODE};
                            end
                        end
                    end
                    fpdi_pkg::PH_DUMMY: begin
                        s_d.bytecnt = s_q.bytecnt + 2'h1;
                        // R9: three dummies then code
                        if (s_q.bytecnt == 2'h2) begin
                            s_d.phase = fpdi_pkg::PH_OUT;
                            s_d.out_word = {16'h0000, fpdi_pkg::DEVICE_CODE};
                            s_d.out_len = 5'h07;
                            s_d.out_idx = 5'h07;
                        end
                    end
                    fpdi_pkg::PH_DATA: begin
                        // R19: R17: locked or foreign address ignored
                        if (otp_hit && !otp_lock_bits_i[otp_sector] &&
                            s_q.otp_count != 9'(fpdi_pkg::OTP_MAX_BYTES)) begin
                            s_d.otp_wr = 1'b1;
                            s_d.otp_data = byte_in;
                            s_d.otp_addr = s_q.addr;
                            s_d.otp_count = s_q.otp_count + 9'h001;
                            s_d.otp_armed = 1'b1;
                            // Wrap inside the 256-byte window
                            s_d.addr = {s_q.addr[23:8], s_q.addr[7:0] + 8'h01};
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // R22: output on falling edges, repeating
        if (!csn && sclk_fall && s_q.phase == fpdi_pkg::PH_OUT) begin
            s_d.out_bit = s_q.out_word[s_q.out_idx];
            s_d.out_idx = (s_q.out_idx == 5'h00) ? s_q.out_len : s_q.out_idx - 5'h01;
        end

        if (cs_rise) begin
            s_d.phase = fpdi_pkg::PH_IGNORE;
            s_d.out_bit = 1'b0;
            // R4: R1: R5: only exact-boundary entry
            if (s_q.sleep_ok && s_q.bitcnt == 3'h0 && !busy) begin
                s_d.power = fpdi_pkg::PW_ENTERING;
                s_d.tmr = fpdi_pkg::TMR_W'(fpdi_pkg::SLEEP_ENTRY_CYC);
            end
            // R10: R8: wake from sleep after delay
            if (s_q.power == fpdi_pkg::PW_SLEEP && s_q.op == fpdi_pkg::OP_WAKE_AND_CODE) begin
                s_d.power = fpdi_pkg::PW_WAKING;
                // Wake-only frame: opcode alone, no dummy byte completed
                s_d.tmr = (s_q.phase == fpdi_pkg::PH_DUMMY && s_q.bytecnt == 2'h0)
                    ? fpdi_pkg::TMR_W'(fpdi_pkg::WAKE_SHORT_CYC)
                    : fpdi_pkg::TMR_W'(fpdi_pkg::WAKE_READ_CYC);
            end
            // R25: program cycle at byte boundary
            if (s_q.phase == fpdi_pkg::PH_DATA && s_q.otp_armed && s_q.bitcnt == 3'h0) begin
                s_d.power = fpdi_pkg::PW_BUSY;
                s_d.tmr = fpdi_pkg::TMR_W'(fpdi_pkg::OTP_PROG_CYC);
            end
        end
    end

    // R7: reset always lands in standby
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.csn_s <= 2'h3;
            s_q.csn_prev <= 1'b1;
            s_q.phase <= fpdi_pkg::PH_IGNORE;
            s_q.power <= fpdi_pkg::PW_STANDBY;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign serial_out_o = s_q.out_bit;
    assign serial_out_oe_o = ~csn & (s_q.phase == fpdi_pkg::PH_OUT);
    assign busy_flag_o = busy;
    assign write_enable_latch_o = s_q.write_enable_latch;
    assign asleep_o = (s_q.power == fpdi_pkg::PW_SLEEP);
    // R3: standby distinct from sleep
    assign standby_o = csn & ~busy & (s_q.power == fpdi_pkg::PW_STANDBY);
    assign otp_wr_o = '{otp_wr: s_q.otp_wr, otp_addr: s_q.otp_addr, otp_data: s_q.otp_data};

endmodule

/* File: fpdi_pkg.sv */
/*
 * Package for the flash sleep, identity and OTP-program command block.
 * Assumes one 40 MHz system clock; the serial link is sampled, not clocked.
 */
package fpdi_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_SLEEP_ENTRY = 8'hB9;
    localparam logic [7:0] OP_WAKE_AND_CODE = 8'hAB;
    localparam logic [7:0] OP_MAKER_DEV = 8'h90;
    localparam logic [7:0] OP_IDENT_READ = 8'h9F;
    localparam logic [7:0] OP_OTP_PROGRAM = 8'h42;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_SOFT_RESET = 8'h99;

    // ------------------------------------------------------------------
    // Identity values (arbitrary, neutral)
    // ------------------------------------------------------------------
    localparam logic [7:0] MAKER_CODE = 8'h5A;
    localparam logic [7:0] DEVICE_CODE = 8'h17;
    localparam logic [7:0] MEM_TYPE = 8'h70;
    localparam logic [7:0] CAPACITY = 8'h18;

    // ------------------------------------------------------------------
    // OTP sector map
    // ------------------------------------------------------------------
    localparam logic [23:0] OTP_BASE_0 = 24'hFFF000;
    localparam logic [23:0] OTP_BASE_1 = 24'hFFE000;
    localparam logic [23:0] OTP_BASE_2 = 24'hFFD000;
    localparam logic [23:0] OTP_SPAN_MASK = 24'h0001FF;
    localparam logic [23:0] ADDR_DEV_FIRST = 24'h000001;
    localparam int OTP_MAX_BYTES = 256;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int WAKE_DELAY_SHORT_NS = 3000;
    localparam int WAKE_DELAY_WITH_READ_NS = 1800;
    localparam int OTP_PROGRAM_TIME_NS = 100000;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SHORT_CYC = WAKE_DELAY_SHORT_NS / CLK_PERIOD_NS;
    localparam int WAKE_READ_CYC = WAKE_DELAY_WITH_READ_NS / CLK_PERIOD_NS;
    localparam int OTP_PROG_CYC = OTP_PROGRAM_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 13;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_OPCODE,
        PH_ADDR,
        PH_DUMMY,
        PH_OUT,
        PH_DATA,
        PH_IGNORE
    } fpdi_phase_t;

    typedef enum logic [2:0] {
        PW_STANDBY,
        PW_ENTERING,
        PW_SLEEP,
        PW_WAKING,
        PW_BUSY
    } fpdi_power_t;

    typedef struct packed {
        logic csn;
        logic sclk;
        logic sin;
    } fpdi_link_t;

    typedef struct packed {
        logic otp_wr;
        logic [23:0] otp_addr;
        logic [7:0] otp_data;
    } fpdi_otp_wr_t;

    typedef struct packed {
        logic [1:0] csn_s;
        logic [1:0] sclk_s;
        logic [1:0] sin_s;
        logic sclk_prev;
        logic csn_prev;
        fpdi_phase_t phase;
        fpdi_power_t power;
        logic [7:0] op;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic [1:0] bytecnt;
        logic [23:0] addr;
        logic [23:0] out_word;
        logic [4:0] out_idx;
        logic [4:0] out_len;
        logic out_bit;
        logic sleep_ok;
        logic write_enable_latch;
        logic otp_armed;
        logic [8:0] otp_count;
        logic [TMR_W-1:0] tmr;
        logic otp_wr;
        logic [23:0] otp_addr;
        logic [7:0] otp_data;
    } fpdi_state_t;

endpackage

/* File: fpdi_cmd_asserts.sv */
/*
 * Checker for the flash sleep, identity and OTP-program command block.
 * Assumes it is bound to fpdi_cmd and sees only that module's ports.
 */
`timescale 1ns/100ps
module fpdi_cmd_asserts (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire fpdi_pkg::fpdi_link_t link_i,
    input wire logic [2:0] otp_lock_bits_i,
    input wire logic quad_command_mode_i,
    input wire logic ext_busy_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    input wire logic busy_flag_o,
    input wire logic write_enable_latch_o,
    input wire logic asleep_o,
    input wire logic standby_o,
    input wire fpdi_pkg::fpdi_otp_wr_t otp_wr_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    logic [11:0] sec;
    assign sec = otp_wr_o.otp_addr[23:12];

    a_busy_from_ext: assert property (ext_busy_i [*3] |-> busy_flag_o)
        else $error("busy flag low during external cycle");
    a_prog_busy_holds: assert property ($rose(busy_flag_o) && !ext_busy_i |=>
        busy_flag_o [*8])
        else $error("program cycle ended too soon");
    a_sleep_entry: assert property ($rose(asleep_o) |->
        link_i.csn && $past(link_i.csn, 100) && !busy_flag_o)
        else $error("sleep entered too early or while busy");
    a_sleep_no_standby: assert property (asleep_o |-> !standby_o)
        else $error("standby shown while asleep");
    a_standby_deselect: assert property (!link_i.csn [*4] |-> !standby_o)
        else $error("standby shown while selected");
    a_oe_deselect: assert property (link_i.csn [*4] |-> !serial_out_oe_o)
        else $error("output driven while deselected");
    a_out_on_fall: assert property (serial_out_oe_o && $past(serial_out_oe_o) &&
        $changed(serial_out_o) |-> !$past(link_i.sclk, 2))
        else $error("output bit changed away from falling edge");
    a_otp_needs_wel: assert property (otp_wr_o.otp_wr |->
        write_enable_latch_o && !busy_flag_o)
        else $error("otp write without latch or while busy");
    a_otp_unlocked: assert property (otp_wr_o.otp_wr |-> !((sec == 12'hFFF &&
        otp_lock_bits_i[0]) || (sec == 12'hFFE && otp_lock_bits_i[1]) ||
        (sec == 12'hFFD && otp_lock_bits_i[2])))
        else $error("otp write into locked sector");
    a_otp_range: assert property (otp_wr_o.otp_wr |->
        sec inside {12'hFFF, 12'hFFE, 12'hFFD} && otp_wr_o.otp_addr[11:9] == 3'h0)
        else $error("otp write outside sectors");
    a_otp_pulse: assert property (otp_wr_o.otp_wr |=> !otp_wr_o.otp_wr)
        else $error("otp write pulse longer than one cycle");
    a_wel_clears: assert property ($fell(busy_flag_o) && !ext_busy_i &&
        !$past(ext_busy_i) && !$past(ext_busy_i, 2) |-> ##[0:2] !write_enable_latch_o)
        else $error("latch kept after program cycle");
    a_asleep_quiet: assert property (asleep_o |-> !otp_wr_o.otp_wr)
        else $error("otp write while asleep");
endmodule

bind fpdi_cmd fpdi_cmd_asserts fpdi_cmd_asserts_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .link_i(link_i), .otp_lock_bits_i(otp_lock_bits_i),
    .quad_command_mode_i(quad_command_mode_i), .ext_busy_i(ext_busy_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .busy_flag_o(busy_flag_o), .write_enable_latch_o(write_enable_latch_o),
    .asleep_o(asleep_o), .standby_o(standby_o), .otp_wr_o(otp_wr_o)
);

/* File: fpdi_host.sv */
/*
 * Serial host model: chip select, serial clock and data toward the block.
 * Assumes clk_i is the block's clock; the serial clock runs at 200 ns.
 */
`timescale 1ns/100ps
module fpdi_host (
    input wire logic clk_i,
    input wire logic sout_i,
    input wire logic soe_i,
    output fpdi_pkg::fpdi_link_t link_o
);
    logic act;

    initial begin
        link_o = 3'h4;
        act = 1'b0;
    end

    // Idle data line toggles so a stale bit never looks valid
    always @(posedge clk_i) begin
        if (!act) begin
            link_o.sin <= ~link_o.sin;
        end
    end

    // ------------------------------------------------------------
    // Frame: bits MSB first, four clocks per serial clock phase
    // ------------------------------------------------------------
    task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        act = 1'b1;
        @(posedge clk_i);
        // select held for the whole frame
        link_o.csn <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            link_o.sin <= tx[i];
            link_o.sclk <= 1'b0;
            repeat (4) @(posedge clk_i);
            link_o.sclk <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx = {rx[62:0], soe_i ? sout_i : ~rx[0]};
        end
        link_o.sclk <= 1'b0;
        repeat (4) @(posedge clk_i);
        // deselect right after the last bit
        link_o.csn <= 1'b1;
        act = 1'b0;
    endtask
endmodule

/* File: tb.sv */
/*
 * Self-checking bench for fpdi_cmd with the serial host model.
 * Assumes the package and both modules are compiled before it.
 */
`timescale 1ns/100ps
module tb;
    logic clk_i;
    logic rstn_i;
    fpdi_pkg::fpdi_link_t link;
    logic [2:0] lock;
    logic quad;
    logic ext_busy;
    logic sout;
    logic soe;
    logic busy;
    logic write_enable_latch;
    logic asleep;
    logic standby;
    fpdi_pkg::fpdi_otp_wr_t otp;
    integer seed;
    int mismatches;
    int checks_done;
    int oe_cnt = 0;
    int n0;
    logic [63:0] rx;
    logic [7:0] d;
    logic [7:0] d2;
    logic [23:0] base;
    logic [31:0] expq[$];

    fpdi_cmd fpdi_cmd_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .link_i(link), .otp_lock_bits_i(lock),
        .quad_command_mode_i(quad), .ext_busy_i(ext_busy), .serial_out_o(sout),
        .serial_out_oe_o(soe), .busy_flag_o(busy), .write_enable_latch_o(write_enable_latch),
        .asleep_o(asleep), .standby_o(standby), .otp_wr_o(otp)
    );
    fpdi_host fpdi_host_i (.clk_i(clk_i), .sout_i(sout), .soe_i(soe), .link_o(link));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic run(input int n, input logic [63:0] tx);
        fpdi_host_i.xfer(n, tx, rx);
        repeat (150) @(posedge clk_i);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge clk_i);
            n++;
            if (n > 5000) begin
                mismatches++;
                summarize();
            end
        end
    endtask

    // ------------------------------------------------------------
    // Monitors: output enable count and otp write notes
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (soe === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
        if (otp.otp_wr === 1'b1) begin
            if (expq.size() == 0) begin
                chk("otp unexpected", 1'b1, 1'b0);
            end else begin
                chk("otp write", {otp.otp_addr, otp.otp_data}, expq.pop_front());
            end
        end
    end

    initial begin
        seed = 32'hC2C3;
        rstn_i = 1'b0;
        lock = 3'h0;
        quad = 1'b0;
        ext_busy = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("power up", {standby, asleep, busy, write_enable_latch}, 4'h8);
        run(32, {8'h9F, 24'h0});
        chk("ident", rx[23:0], {fpdi_pkg::MAKER_CODE, fpdi_pkg::MEM_TYPE,
            fpdi_pkg::CAPACITY});
        run(48, {8'h90, 24'h0, 16'h0});
        chk("maker first", rx[15:0], {fpdi_pkg::MAKER_CODE, fpdi_pkg::DEVICE_CODE});
        run(48, {8'h90, 24'h1, 16'h0});
        chk("device first", rx[15:0], {fpdi_pkg::DEVICE_CODE, fpdi_pkg::MAKER_CODE});
        run(48, {8'hAB, 24'h0, 16'h0});
        chk("device code", rx[15:0], {2{fpdi_pkg::DEVICE_CODE}});
        run(7, 64'h5C);
        chk("short sleep frame", asleep, 1'b0);
        run(9, 64'h172);
        chk("long sleep frame", asleep, 1'b0);
        run(40, {8'h42, fpdi_pkg::OTP_BASE_0, 8'h00});
        chk("program without latch", {busy, write_enable_latch}, 2'b00);
        ext_busy <= 1'b1;
        n0 = oe_cnt;
        run(8, 64'hB9);
        run(32, {8'h9F, 24'h0});
        run(48, {8'hAB, 24'h0, 16'h0});
        chk("busy refuses", {asleep, busy, oe_cnt == n0}, 3'h3);
        ext_busy <= 1'b0;
        // select held high through the wake delays
        for (int k = 0; k < 3; k++) begin
            fpdi_host_i.xfer(8, 64'hB9, rx);
            repeat (110) @(posedge clk_i);
            chk("entry delay", asleep, 1'b0);
            repeat (40) @(posedge clk_i);
            chk("asleep", {asleep, standby}, 2'b10);
            if (k == 0) begin
                n0 = oe_cnt;
                run(8, 64'h06);
                run(48, {8'h90, 40'h0});
                chk("sleep ignores", {asleep, write_enable_latch, oe_cnt == n0}, 3'h5);
            end
            fpdi_host_i.xfer(k == 2 ? 48 : 8,
                k == 0 ? 64'hAB : k == 1 ? 64'h99 : 64'hAB << 40, rx);
            repeat (100) @(posedge clk_i);
            chk("wake delay", standby, k != 0);
            if (k == 2) begin
                chk("code from sleep", rx[15:0], {2{fpdi_pkg::DEVICE_CODE}});
            end
            repeat (50) @(posedge clk_i);
            chk("awake", {asleep, standby}, 2'b01);
        end
        run(8, 64'hB9);
        chk("asleep before reset", asleep, 1'b1);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("reset wakes", {standby, asleep}, 2'b10);
        for (int s = 0; s < 3; s++) begin
            base = s == 0 ? fpdi_pkg::OTP_BASE_0 : s == 1 ? fpdi_pkg::OTP_BASE_1 :
                fpdi_pkg::OTP_BASE_2;
            quad <= (s == 2);
            lock <= 3'h1 << s;
            run(8, 64'h06);
            chk("latch set", write_enable_latch, 1'b1);
            run(40, {8'h42, base, 8'h00});
            chk("locked ignored", busy, 1'b0);
            wait_idle();
            lock <= ~(3'h1 << s);
            run(8, 64'h06);
            d = 8'($random(seed));
            d2 = 8'($random(seed));
            expq.push_back({base + 24'h1FE, d});
            expq.push_back({base + 24'h1FF, d2});
            fpdi_host_i.xfer(48, {8'h42, base + 24'h1FE, d, d2}, rx);
            repeat (100) @(posedge clk_i);
            chk("program busy", {busy, write_enable_latch}, 2'b11);
            wait_idle();
            repeat (5) @(posedge clk_i);
            chk("program done", {busy, write_enable_latch, expq.size() == 0}, 3'h1);
        end
        summarize();
    end
endmodule
